/* pin_sync.sv */
`timescale 1ns/1ns
module pin_sync
    import sram_array_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic clk_en,
    // pins
    pin_sync_if.sync  pins
);
    logic [BYTE_W-1:0] stage1_ff;
    logic [BYTE_W-1:0] stage2_ff;

    // ------------------------------------------------------------
    // two-flop synchroniser for data returned by the array
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else if (clk_en) begin
            stage1_ff <= pins.raw;
            stage2_ff <= stage1_ff;
        end
    end

    assign pins.synced = stage2_ff;
endmodule : pin_sync

/* pin_sync_if.sv */
`timescale 1ns/1ns
interface pin_sync_if;
    import sram_array_pkg::*;
    logic [BYTE_W-1:0] raw;
    logic [BYTE_W-1:0] synced;
    modport owner (output raw, input synced);
    modport sync  (input raw, output synced);
endinterface : pin_sync_if

/* ram_half_model.sv */
`timescale 1ns/1ns
module ram_half_model
    import sram_array_pkg::*;
(
    // array pins of one half
    input wire logic [ADDR_W-1:0]   addr,
    input wire logic                low_sel_n,
    input wire logic                high_sel_n,
    input wire logic                wr_n,
    input wire logic [NIBBLE_W-1:0] din,
    output logic [NIBBLE_W-1:0]     dout,
    // access time, set by the bench
    input int                       acc_ns
);
    logic [NIBBLE_W-1:0] mem [8192];
    logic [12:0]         at;
    time                 t0;
    wire                 on = !(low_sel_n && high_sel_n);

    // address taken at the select's falling edge
    always @(posedge on) begin
        at = {!high_sel_n, addr};
        t0 = $time;
    end

    // undriven output toggles so a stale sample never matches
    initial dout = '0;
    always #1 begin
        if (on && !wr_n) mem[at] = din;
        dout = (on && wr_n && $time - t0 >= acc_ns) ? mem[at] : ~dout;
    end
endmodule : ram_half_model

/* sram_array_host.sv */
`timescale 1ns/1ns
module sram_array_host
    import sram_array_pkg::*;
(
    // clock, reset, enable
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    // configuration and power
    input  wire logic                  byte_mode,
    input  wire logic                  retain_req,
    input  wire logic                  supply_ok,
    // user request
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire logic                  req_write,
    input  wire logic [USER_ADDR_W-1:0] req_addr,
    input  wire logic [BYTE_W-1:0]     req_wdata,
    output logic                       rd_valid,
    output logic [BYTE_W-1:0]          rd_data,
    // array pins
    output logic [ADDR_W-1:0]          mem_addr,
    output logic                       block_a_low_select,
    output logic                       block_a_high_select,
    output logic                       block_b_low_select,
    output logic                       block_b_high_select,
    output logic                       block_a_write_strobe,
    output logic                       block_b_write_strobe,
    output logic [NIBBLE_W-1:0]        block_a_din,
    output logic [NIBBLE_W-1:0]        block_b_din,
    input  wire logic [NIBBLE_W-1:0]   block_a_dout,
    input  wire logic [NIBBLE_W-1:0]   block_b_dout
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ctrl_state_e              state_ff;
    logic [CNT_W-1:0]         cnt_ff;
    logic [SEL_N-1:0]         sel_low_ff;
    logic [SEL_N-1:0]         sel_pick_ff;
    logic                     write_ff;
    logic                     nibble_hi_ff;
    logic                     mode_ff;
    logic [ADDR_W-1:0]        addr_ff;
    logic [BYTE_W-1:0]        wdata_ff;
    logic                     wstrobe_ff;
    logic                     ok_s1_ff;
    logic                     ok_s2_ff;
    logic                     ret_s1_ff;
    logic                     ret_s2_ff;
    logic [SEL_N-1:0]         nxt_sel;
    logic                     cnt_done;

    pin_sync_if rd_pins ();

    assign rd_pins.raw = {block_b_dout, block_a_dout};

    pin_sync u_rd_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .pins    (rd_pins)
    );

    // ------------------------------------------------------------
    // supply and retention inputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ok_s1_ff  <= 1'b0;
            ok_s2_ff  <= 1'b0;
            ret_s1_ff <= 1'b0;
            ret_s2_ff <= 1'b0;
        end else if (clk_en) begin
            ok_s1_ff  <= supply_ok;
            ok_s2_ff  <= ok_s1_ff;
            ret_s1_ff <= retain_req;
            ret_s2_ff <= ret_s1_ff;
        end
    end

    assign cnt_done = (cnt_ff == '0);

    // ------------------------------------------------------------
    // select decode
    // ------------------------------------------------------------
    // select index order: a_low, a_high, b_low, b_high
    always_comb begin
        nxt_sel = '0;
        if (byte_mode) begin
            // both halves of one address half together
            nxt_sel = req_addr[ADDR_W] ? 4'hA : 4'h5;
        end else begin
            // one select per 4K quarter, halves kept apart
            nxt_sel[req_addr[ADDR_W +: 2]] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff     <= ST_RECOVER;
            cnt_ff       <= CNT_W'(MIN_ENABLE_HIGH_CYC);
            sel_low_ff   <= '0;
            sel_pick_ff  <= '0;
            write_ff     <= 1'b0;
            nibble_hi_ff <= 1'b0;
            mode_ff      <= 1'b0;
            wstrobe_ff   <= 1'b0;
        end else if (clk_en) begin
            if (!cnt_done) begin
                cnt_ff <= cnt_ff - CNT_W'(1);
            end
            case (state_ff)
                ST_RECOVER: begin
                    // supply not yet good: hold the interval count loaded
                    sel_low_ff <= '0;
                    if (!ok_s2_ff) begin
                        cnt_ff <= CNT_W'(MIN_ENABLE_HIGH_CYC);
                    end else if (cnt_done) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (ret_s2_ff || !ok_s2_ff) begin
                        state_ff <= ST_RETAIN;
                    end else if (req_valid) begin
                        sel_pick_ff  <= nxt_sel;
                        write_ff     <= req_write;
                        mode_ff      <= byte_mode;
                        nibble_hi_ff <= req_addr[ADDR_W+1];
                        cnt_ff       <= CNT_W'(ADDR_SETUP_CYC);
                        state_ff     <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt_done) begin
                        // single fall, only from all-high
                        sel_low_ff <= sel_pick_ff;
                        wstrobe_ff <= write_ff;
                        cnt_ff     <= CNT_W'(ENABLE_LOW_CYC);
                        state_ff   <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (cnt_done) begin
                        // strobe and select rise together, data held past
                        sel_low_ff <= '0;
                        wstrobe_ff <= 1'b0;
                        cnt_ff     <= CNT_W'(MIN_ENABLE_HIGH_CYC);
                        state_ff   <= ST_PRECHARGE;
                    end
                end
                ST_PRECHARGE: begin
                    // every select high a full interval between cycles
                    if (cnt_done) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_RETAIN: begin
                    // selects and write strobes high, address and data parked low
                    sel_low_ff <= '0;
                    if (!ret_s2_ff && ok_s2_ff) begin
                        cnt_ff   <= CNT_W'(MIN_ENABLE_HIGH_CYC);
                        state_ff <= ST_RECOVER;
                    end else if (!ok_s2_ff) begin
                        cnt_ff <= CNT_W'(MIN_ENABLE_HIGH_CYC);
                    end
                end
                default: begin
                    state_ff   <= ST_RECOVER;
                    sel_low_ff <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // address and write data registers
    // ------------------------------------------------------------
    // address held through the whole low phase, which covers hold time
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            addr_ff  <= '0;
            wdata_ff <= '0;
        end else if (clk_en) begin
            if (state_ff == ST_IDLE && req_valid && !ret_s2_ff && ok_s2_ff) begin
                addr_ff  <= req_addr[ADDR_W-1:0];
                wdata_ff <= req_write ? req_wdata : '0;
            end else if (state_ff == ST_RETAIN) begin
                addr_ff  <= '0;
                wdata_ff <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // read capture
    // ------------------------------------------------------------
    // sampled at end of the low phase; sync leaves 348 ns of it for access, under the 350 ns access time
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else if (clk_en) begin
            rd_valid <= 1'b0;
            if (state_ff == ST_ACTIVE && cnt_done && !write_ff) begin
                rd_valid <= 1'b1;
                if (mode_ff) begin
                    // half a carries the upper nibble of a byte
                    rd_data <= {rd_pins.synced[NIBBLE_W-1:0], rd_pins.synced[BYTE_W-1:NIBBLE_W]};
                end else if (nibble_hi_ff) begin
                    rd_data <= {4'h0, rd_pins.synced[BYTE_W-1:NIBBLE_W]};
                end else begin
                    rd_data <= {4'h0, rd_pins.synced[NIBBLE_W-1:0]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    assign req_ready            = (state_ff == ST_IDLE) && !ret_s2_ff && ok_s2_ff;
    assign mem_addr             = addr_ff;
    assign block_a_low_select   = ~sel_low_ff[0];
    assign block_a_high_select  = ~sel_low_ff[1];
    assign block_b_low_select   = ~sel_low_ff[2];
    assign block_b_high_select  = ~sel_low_ff[3];
    assign block_a_write_strobe = ~(wstrobe_ff & (mode_ff | ~nibble_hi_ff));
    assign block_b_write_strobe = ~(wstrobe_ff & (mode_ff | nibble_hi_ff));
    assign block_a_din          = mode_ff ? wdata_ff[BYTE_W-1:NIBBLE_W] : wdata_ff[NIBBLE_W-1:0];
    assign block_b_din          = wdata_ff[NIBBLE_W-1:0];

endmodule : sram_array_host

/* sram_array_host_props.sv */
`timescale 1ns/1ns
module sram_array_host_props
    import sram_array_pkg::*;
(
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              resetn,
    // watched ports
    input wire logic              byte_mode,
    input wire logic              supply_ok,
    input wire logic              rd_valid,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              block_a_low_select,
    input wire logic              block_a_high_select,
    input wire logic              block_b_low_select,
    input wire logic              block_b_high_select,
    input wire logic              block_a_write_strobe,
    input wire logic              block_b_write_strobe
);
    logic [3:0] sel_n;
    logic       all_hi;
    logic [8:0] hi_ff;
    logic [8:0] lo_ff;
    logic [8:0] up_ff;
    logic [8:0] dn_ff;

    assign sel_n  = {block_b_high_select, block_b_low_select, block_a_high_select, block_a_low_select};
    assign all_hi = &sel_n;

    // ----------------------------------------
    // run lengths, saturating
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hi_ff <= '0;
            lo_ff <= '0;
        end else begin
            hi_ff <= all_hi ? hi_ff + 9'(hi_ff != '1) : '0;
            lo_ff <= all_hi ? '0 : lo_ff + 9'(lo_ff != '1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            up_ff <= '0;
            dn_ff <= '0;
        end else begin
            up_ff <= supply_ok ? up_ff + 9'(up_ff != '1) : '0;
            dn_ff <= supply_ok ? '0 : dn_ff + 9'(dn_ff != '1);
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_high_first;
        $fell(all_hi) |-> hi_ff >= MIN_ENABLE_HIGH_CYC;
    endproperty
    a_high_first: assert property (p_high_first) else $error("select fell too soon");
    property p_low_width;
        $rose(all_hi) |-> lo_ff >= ENABLE_LOW_CYC;
    endproperty
    a_low_width: assert property (p_low_width) else $error("select low too short");
    property p_recover;
        $fell(all_hi) |-> up_ff >= MIN_ENABLE_HIGH_CYC;
    endproperty
    a_recover: assert property (p_recover) else $error("cycle too soon after supply");
    property p_retain_hi;
        dn_ff >= 200 |-> all_hi && block_a_write_strobe && block_b_write_strobe;
    endproperty
    a_retain_hi: assert property (p_retain_hi) else $error("select low in retention");
    property p_nibble_one;
        !byte_mode |-> $countones(sel_n) >= 3;
    endproperty
    a_nibble_one: assert property (p_nibble_one) else $error("two selects low");
    property p_byte_pair;
        byte_mode |-> block_a_low_select == block_b_low_select && block_a_high_select == block_b_high_select;
    endproperty
    a_byte_pair: assert property (p_byte_pair) else $error("byte selects not paired");
    property p_addr_hold;
        $fell(all_hi) |-> $stable(mem_addr) ##1 $stable(mem_addr) [*8];
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved at select");
    property p_strobe_sel;
        !(block_a_write_strobe && block_b_write_strobe) |-> !all_hi;
    endproperty
    a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");
    property p_rd_answer;
        $rose(all_hi) && $past(block_a_write_strobe && block_b_write_strobe) |-> rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read gave no answer");
endmodule : sram_array_host_props

bind sram_array_host sram_array_host_props props_inst (
    .ref_clk              (ref_clk),
    .resetn               (resetn),
    .byte_mode            (byte_mode),
    .supply_ok            (supply_ok),
    .rd_valid             (rd_valid),
    .mem_addr             (mem_addr),
    .block_a_low_select   (block_a_low_select),
    .block_a_high_select  (block_a_high_select),
    .block_b_low_select   (block_b_low_select),
    .block_b_high_select  (block_b_high_select),
    .block_a_write_strobe (block_a_write_strobe),
    .block_b_write_strobe (block_b_write_strobe)
);

/* sram_array_pkg.sv */
package sram_array_pkg;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W        = 12;
    localparam int NIBBLE_W      = 4;
    localparam int BYTE_W        = 8;
    localparam int SEL_N         = 4;
    localparam int USER_ADDR_W   = 14;

    // ------------------------------------------------------------
    // timing (ns figures, cycle counts at the 250 MHz ref_clk)
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_ENABLE_HIGH_NS = 150;
    localparam int T_ENABLE_LOW_NS  = 350;
    localparam int T_ADDR_SETUP_NS  = 10;
    localparam int T_ADDR_HOLD_NS   = 70;
    localparam int T_DATA_SETUP_NS  = 170;
    localparam int T_ACCESS_NS      = 350;

    localparam int MIN_ENABLE_HIGH_CYC = (T_ENABLE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ENABLE_LOW_CYC      = (T_ENABLE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_SETUP_CYC      = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_HOLD_CYC       = (T_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_SETUP_CYC      = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC          = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RECOVER,
        ST_IDLE,
        ST_SETUP,
        ST_ACTIVE,
        ST_PRECHARGE,
        ST_RETAIN
    } ctrl_state_e;

endpackage : sram_array_pkg

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top
    import sram_array_pkg::*;
;
    logic ref_clk, resetn, clk_en, byte_mode, retain_req, supply_ok;
    logic req_valid, req_ready, req_write, rd_valid;
    logic block_a_low_select, block_a_high_select, block_b_low_select, block_b_high_select;
    logic block_a_write_strobe, block_b_write_strobe;
    logic [USER_ADDR_W-1:0] req_addr;
    logic [BYTE_W-1:0]      req_wdata, rd_data;
    logic [ADDR_W-1:0]      mem_addr;
    logic [NIBBLE_W-1:0]    block_a_din, block_b_din, block_a_dout, block_b_dout;
    int                     acc_ns, err_count, n_tests;

    sram_array_host sram_array_host_inst (
        .ref_clk              (ref_clk),
        .resetn               (resetn),
        .clk_en               (clk_en),
        .byte_mode            (byte_mode),
        .retain_req           (retain_req),
        .supply_ok            (supply_ok),
        .req_valid            (req_valid),
        .req_ready            (req_ready),
        .req_write            (req_write),
        .req_addr             (req_addr),
        .req_wdata            (req_wdata),
        .rd_valid             (rd_valid),
        .rd_data              (rd_data),
        .mem_addr             (mem_addr),
        .block_a_low_select   (block_a_low_select),
        .block_a_high_select  (block_a_high_select),
        .block_b_low_select   (block_b_low_select),
        .block_b_high_select  (block_b_high_select),
        .block_a_write_strobe (block_a_write_strobe),
        .block_b_write_strobe (block_b_write_strobe),
        .block_a_din          (block_a_din),
        .block_b_din          (block_b_din),
        .block_a_dout         (block_a_dout),
        .block_b_dout         (block_b_dout)
    );
    ram_half_model half_a (.addr(mem_addr), .low_sel_n(block_a_low_select), .high_sel_n(block_a_high_select),
        .wr_n(block_a_write_strobe), .din(block_a_din), .dout(block_a_dout), .acc_ns(acc_ns));
    ram_half_model half_b (.addr(mem_addr), .low_sel_n(block_b_low_select), .high_sel_n(block_b_high_select),
        .wr_n(block_b_write_strobe), .din(block_b_din), .dout(block_b_dout), .acc_ns(acc_ns));

    initial begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk8(input logic [7:0] e, input logic [7:0] g, input string m);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask : chk8

    task automatic chk_ge(input int g, input int lo, input string m);
        n_tests++;
        if (g < lo) begin
            err_count++;
            $display("unexpected at %0t: %s %0d below %0d", $time, m, g, lo);
        end
    endtask : chk_ge

    // entered just after an edge; request held until ready is seen
    task automatic do_req(input logic w, input logic [13:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        req_valid = 1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && n < 600) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk_ge(599 - n, 0, "ready wait");
        @(posedge ref_clk);
        #1 req_valid = 0;
        n = 0;
        while (!w && rd_valid !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1 n++;
        end
        q = rd_data;
        chk_ge(299 - n, 0, "answer wait");
        // a gap edge so valid is never lowered and raised in one step
        @(posedge ref_clk);
        #1;
    endtask : do_req

    task automatic t_byte;
        logic [7:0] q;
        do_req(1, 14'h0000, 8'h5A, q);
        do_req(1, 14'h1FFF, 8'hC3, q);
        do_req(1, 14'h2ABC, 8'h96, q);
        do_req(0, 14'h0000, 8'h00, q);
        chk8(8'h5A, q, "byte low half");
        do_req(0, 14'h1FFF, 8'h00, q);
        chk8(8'hC3, q, "byte high half");
        do_req(0, 14'h0ABC, 8'h00, q);
        chk8(8'h96, q, "byte top bit ignored");
    endtask : t_byte

    task automatic t_nibble;
        logic [7:0] q;
        byte_mode = 0;
        acc_ns = 340;
        for (int i = 0; i < 4; i++) do_req(1, {2'(i), 12'h123}, {4'hF, 4'(3 * i + 1)}, q);
        for (int i = 0; i < 4; i++) begin
            do_req(0, {2'(i), 12'h123}, 8'h00, q);
            chk8({4'h0, 4'(3 * i + 1)}, q, "nibble select");
        end
        do_req(0, 14'h0000, 8'h00, q);
        chk8(8'h05, q, "half a nibble");
        do_req(0, 14'h2000, 8'h00, q);
        chk8(8'h0A, q, "half b nibble");
    endtask : t_nibble

    task automatic t_retain;
        logic [7:0] q;
        int         n;
        byte_mode = 1;
        acc_ns = 40;
        retain_req = 1;
        repeat (150) @(posedge ref_clk);
        #1 chk8(8'h00, {7'h0, req_ready}, "ready in retention");
        retain_req = 0;
        supply_ok = 0;
        repeat (250) @(posedge ref_clk);
        #1 chk8(8'h0F, {4'h0, block_b_high_select, block_b_low_select, block_a_high_select, block_a_low_select},
            "selects in retention");
        supply_ok = 1;
        n = 0;
        while (req_ready !== 1'b1 && n < 500) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk_ge(n, MIN_ENABLE_HIGH_CYC, "recovery wait");
        do_req(0, 14'h1FFF, 8'h00, q);
        chk8(8'hC3, q, "data kept");
    endtask : t_retain

    task automatic stop_test;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        #100000;
        err_count++;
        stop_test;
    end

    initial begin
        {resetn, req_valid, req_write, retain_req, err_count, n_tests} = '0;
        {clk_en, byte_mode, supply_ok} = 3'b111;
        req_addr = '0;
        req_wdata = '0;
        acc_ns = 40;
        repeat (3) @(posedge ref_clk);
        #1 resetn = 1;
        t_byte;
        t_nibble;
        t_retain;
        stop_test;
    end
endmodule : tb_top
